// ### irt_map.vh
`ifndef IRT_MAP_VH
`define IRT_MAP_VH

// Register byte addresses.
`define IRT_ADDR_CFG        16'h5340
`define IRT_ADDR_PSC        16'h5341
`define IRT_ADDR_CARH       16'h5342
`define IRT_ADDR_CARL       16'h5343
`define IRT_ADDR_ST         16'h5344
`define IRT_ADDR_LCNT       16'h5345
`define IRT_ADDR_IMSK       16'h5346
`define IRT_ADDR_IFLG       16'h5347

// Configuration fields.
`define IRT_CFG_EN_BIT      0
`define IRT_CFG_DIR_BIT     1

// Prescaler tap select fields.
`define IRT_PSC_CAR_MSB     7
`define IRT_PSC_CAR_LSB     4
`define IRT_PSC_LEN_MSB     3
`define IRT_PSC_LEN_LSB     0
`define IRT_SEL_RESERVED    4'hF

// Carrier length fields.
`define IRT_CAR_MSB         5
`define IRT_CAR_LSB         0

// Status and interrupt fields.
`define IRT_ST_DATA_BIT     0
`define IRT_INT_UF_BIT      0
`define IRT_INT_RISE_BIT    1
`define IRT_INT_FALL_BIT    2

// Reset values.
`define IRT_RST_CFG         2'h0
`define IRT_RST_PSC         8'h00
`define IRT_RST_CAR         6'h00
`define IRT_RST_LCNT        8'h00
`define IRT_RST_INT         3'h0

`endif

// ### irt_tap_mux.v
`timescale 1ns/1ps
`default_nettype none

// Picks one prescaler tap strobe out of the divide-by-1 to divide-by-16K set.
module irt_tap_mux #(
    parameter NUM_TAPS = 15,
    parameter SEL_W    = 4
) (
    input  wire [NUM_TAPS-1:0] i_taps,
    input  wire [SEL_W-1:0]    i_sel,
    output reg                 o_tick
);

    // The reserved code gives no tick at all, so whatever it drives simply freezes.
    always @*
    begin
        o_tick = 1'b0;
        if (i_sel < NUM_TAPS)
        begin
            o_tick = i_taps[i_sel];
        end
    end

endmodule // irt_tap_mux

`default_nettype wire

// ### irt_core.v
// Behaviour
// - Carrier tap from bits 7:4, code 15 reserved.
// - Length tap from bits 3:0, same encoding.
// - High and low periods last setting plus one.
// - Modulator drives data level with carrier out.
// - Eight-bit down-counter stops at zero after underflow.
// - Length counter advances only on its tap.
// - Rising and falling receive edges raise events.
// - Three events: underflow, rising, falling.
// - Direction bit picks transmit/receive, enable starts.
// - Level one gives carrier, zero gives low.
// - Receive level must hold two samples.
// - Flag set only when enabled, write-one clears.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "irt_map.vh"

module irt_core #(
    parameter ADDR_W   = 16,
    parameter DATA_W   = 8,
    parameter NUM_TAPS = 15
) (
    input  wire                i_clk,
    input  wire                i_nrst,
    input  wire [ADDR_W-1:0]   i_addr,
    input  wire [DATA_W-1:0]   i_wdata,
    input  wire                i_wr,
    input  wire                i_rd,
    output reg  [DATA_W-1:0]   o_rdata,
    input  wire [NUM_TAPS-1:0] i_psc_taps,
    input  wire                i_ir_receive_input,
    output reg                 o_ir_transmit_output,
    output wire                o_irq
);

    // Software-visible state.
    reg        ir_block_enable_reg;
    reg        ir_direction_select_reg;
    reg  [7:0] prescaler_tap_select_reg;
    reg  [5:0] carrier_high_length_reg;
    reg  [5:0] carrier_low_length_reg;
    reg        ir_data_level_reg;
    reg  [7:0] pulse_length_count_reg;
    reg  [7:0] pulse_length_count_next;
    reg  [2:0] int_mask_reg;
    reg  [2:0] int_flag_reg;
    reg  [2:0] int_flag_next;

    // Carrier generator state.
    reg        carrier_phase_reg;
    reg  [5:0] carrier_cnt_reg;

    // Receive path state.
    reg        rx_sync1_reg;
    reg        rx_sync2_reg;
    reg        rx_sample_reg;
    reg        rx_level_reg;

    wire       carrier_tick;
    wire       length_tick;
    wire       tx_active;
    wire       rx_active;
    wire       wr_cfg;
    wire       wr_psc;
    wire       wr_carh;
    wire       wr_carl;
    wire       wr_st;
    wire       wr_lcnt;
    wire       wr_imsk;
    wire       wr_iflg;
    wire       underflow_event;
    wire       rise_event;
    wire       fall_event;
    wire [5:0] carrier_limit;
    wire [2:0] event_vec;

    assign tx_active = ir_block_enable_reg & ~ir_direction_select_reg;
    assign rx_active = ir_block_enable_reg & ir_direction_select_reg;

    // Write decode; each strobe is a single cycle from the master.
    assign wr_cfg  = i_wr && (i_addr == `IRT_ADDR_CFG);
    assign wr_psc  = i_wr && (i_addr == `IRT_ADDR_PSC);
    assign wr_carh = i_wr && (i_addr == `IRT_ADDR_CARH);
    assign wr_carl = i_wr && (i_addr == `IRT_ADDR_CARL);
    assign wr_st   = i_wr && (i_addr == `IRT_ADDR_ST);
    assign wr_lcnt = i_wr && (i_addr == `IRT_ADDR_LCNT);
    assign wr_imsk = i_wr && (i_addr == `IRT_ADDR_IMSK);
    assign wr_iflg = i_wr && (i_addr == `IRT_ADDR_IFLG);

    // Carrier clock tap, chosen by the upper select field.
    irt_tap_mux #(
        .NUM_TAPS (NUM_TAPS),
        .SEL_W    (4)
    ) u_car_tap (
        .i_taps   (i_psc_taps),
        .i_sel    (prescaler_tap_select_reg[`IRT_PSC_CAR_MSB:`IRT_PSC_CAR_LSB]),
        .o_tick   (carrier_tick)
    );

    // Length counter clock tap, independent of the carrier choice.
    irt_tap_mux #(
        .NUM_TAPS (NUM_TAPS),
        .SEL_W    (4)
    ) u_len_tap (
        .i_taps   (i_psc_taps),
        .i_sel    (prescaler_tap_select_reg[`IRT_PSC_LEN_MSB:`IRT_PSC_LEN_LSB]),
        .o_tick   (length_tick)
    );

    // Configuration registers. Changing them while enabled is legal but may glitch one period.
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ir_block_enable_reg      <= 1'b0;
            ir_direction_select_reg  <= 1'b0;
            prescaler_tap_select_reg <= `IRT_RST_PSC;
            carrier_high_length_reg  <= `IRT_RST_CAR;
            carrier_low_length_reg   <= `IRT_RST_CAR;
            ir_data_level_reg        <= 1'b0;
            int_mask_reg             <= `IRT_RST_INT;
        end
        else
        begin
            if (wr_cfg)
            begin
                ir_block_enable_reg     <= i_wdata[`IRT_CFG_EN_BIT];
                ir_direction_select_reg <= i_wdata[`IRT_CFG_DIR_BIT];
            end
            if (wr_psc)
            begin
                prescaler_tap_select_reg <= i_wdata[7:0];
            end
            if (wr_carh)
            begin
                carrier_high_length_reg <= i_wdata[`IRT_CAR_MSB:`IRT_CAR_LSB];
            end
            if (wr_carl)
            begin
                carrier_low_length_reg <= i_wdata[`IRT_CAR_MSB:`IRT_CAR_LSB];
            end
            if (wr_st)
            begin
                ir_data_level_reg <= i_wdata[`IRT_ST_DATA_BIT];
            end
            if (wr_imsk)
            begin
                int_mask_reg <= i_wdata[2:0];
            end
        end
    end

    // Terminal count of the phase now running.
    assign carrier_limit = carrier_phase_reg ? carrier_high_length_reg : carrier_low_length_reg;

    // Carrier generator. A phase lasts limit plus one ticks because the count runs from zero
    // up to the limit inclusive. Outside transmit the generator restarts at the high phase.
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            carrier_phase_reg <= 1'b1;
            carrier_cnt_reg   <= 6'h00;
        end
        else if (!tx_active)
        begin
            carrier_phase_reg <= 1'b1;
            carrier_cnt_reg   <= 6'h00;
        end
        else if (carrier_tick)
        begin
            if (carrier_cnt_reg == carrier_limit)
            begin
                carrier_phase_reg <= ~carrier_phase_reg;
                carrier_cnt_reg   <= 6'h00;
            end
            else
            begin
                carrier_cnt_reg <= carrier_cnt_reg + 6'h01;
            end
        end
    end

    // Modulator. Registered so the pin never sees decode glitches; low whenever idle.
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_ir_transmit_output <= 1'b0;
        end
        else
        begin
            o_ir_transmit_output <= tx_active & ir_data_level_reg & carrier_phase_reg;
        end
    end

    // Underflow is the tick that takes the count from one to zero.
    assign underflow_event = ir_block_enable_reg && length_tick && !wr_lcnt &&
                             (pulse_length_count_reg == 8'h01);

    // Data length counter. A software write wins over a tick in the same cycle, so the
    // freshly written value is never shortened by one.
    always @*
    begin
        pulse_length_count_next = pulse_length_count_reg;
        if (wr_lcnt)
        begin
            pulse_length_count_next = i_wdata[7:0];
        end
        else if (ir_block_enable_reg && length_tick && (pulse_length_count_reg != 8'h00))
        begin
            pulse_length_count_next = pulse_length_count_reg - 8'h01;
        end
    end

    // Count register; zero is a resting state until the next write.
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pulse_length_count_reg <= `IRT_RST_LCNT;
        end
        else
        begin
            pulse_length_count_reg <= pulse_length_count_next;
        end
    end

    // Receive pin synchroniser; only the second stage is read downstream.
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rx_sync1_reg <= 1'b0;
            rx_sync2_reg <= 1'b0;
        end
        else
        begin
            rx_sync1_reg <= i_ir_receive_input;
            rx_sync2_reg <= rx_sync1_reg;
        end
    end

    // Edge detector sampled on the carrier tap. A new level is accepted only when two
    // successive samples agree, which filters spikes shorter than one sample period.
    // While idle the tracked level follows the pin so enabling raises no stale edge.
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rx_sample_reg <= 1'b0;
            rx_level_reg  <= 1'b0;
        end
        else if (!rx_active)
        begin
            rx_sample_reg <= rx_sync2_reg;
            rx_level_reg  <= rx_sync2_reg;
        end
        else if (carrier_tick)
        begin
            rx_sample_reg <= rx_sync2_reg;
            if ((rx_sync2_reg == rx_sample_reg) && (rx_sync2_reg != rx_level_reg))
            begin
                rx_level_reg <= rx_sync2_reg;
            end
        end
    end

    // Edge events fire in the cycle the filtered level is about to change.
    assign rise_event = rx_active && carrier_tick && rx_sync2_reg && rx_sample_reg &&
                        !rx_level_reg;
    assign fall_event = rx_active && carrier_tick && !rx_sync2_reg && !rx_sample_reg &&
                        rx_level_reg;

    // Event vector in flag layout.
    assign event_vec = {fall_event, rise_event, underflow_event};

    // Sticky flags. A masked-off source never sets its flag; a set beats a same-cycle clear.
    always @*
    begin
        int_flag_next = int_flag_reg;
        if (wr_iflg)
        begin
            int_flag_next = int_flag_reg & ~i_wdata[2:0];
        end
        int_flag_next = int_flag_next | (event_vec & int_mask_reg);
    end

    // Flag register.
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            int_flag_reg <= `IRT_RST_INT;
        end
        else
        begin
            int_flag_reg <= int_flag_next;
        end
    end

    // Level interrupt while any enabled flag stands.
    assign o_irq = |(int_flag_reg & int_mask_reg);

    // Read port. Data stands one cycle after the strobe; unmapped addresses read zero.
    // In receive mode the status bit shows the filtered pin level instead of the stored level.
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_rdata <= 8'h00;
        end
        else if (i_rd)
        begin
            case (i_addr)
                `IRT_ADDR_CFG:  o_rdata <= {6'h00, ir_direction_select_reg, ir_block_enable_reg};
                `IRT_ADDR_PSC:  o_rdata <= prescaler_tap_select_reg;
                `IRT_ADDR_CARH: o_rdata <= {2'h0, carrier_high_length_reg};
                `IRT_ADDR_CARL: o_rdata <= {2'h0, carrier_low_length_reg};
                `IRT_ADDR_ST:   o_rdata <= {7'h00, (ir_direction_select_reg ? rx_level_reg : ir_data_level_reg)};
                `IRT_ADDR_LCNT: o_rdata <= pulse_length_count_reg;
                `IRT_ADDR_IMSK: o_rdata <= {5'h00, int_mask_reg};
                `IRT_ADDR_IFLG: o_rdata <= {5'h00, int_flag_reg};
                default:        o_rdata <= 8'h00;
            endcase
        end
        else
        begin
            o_rdata <= 8'h00;
        end
    end

endmodule // irt_core

`default_nettype wire

// ### irt_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module irt_core_assertions (
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic [15:0] i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [7:0]  o_rdata,
    input wire logic        o_ir_transmit_output,
    input wire logic        o_irq
);
    logic [7:0] psc_reg;
    logic [5:0] carh_reg;
    logic [2:0] msk_reg;
    logic [2:0] cfg_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // Mirrors of written fields, so reads and the pin are judged from the bus alone.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            psc_reg  <= 8'h00;
            carh_reg <= 6'h00;
            msk_reg  <= 3'h0;
            cfg_reg  <= 3'h0;
        end
        else if (i_wr)
        begin
            if (i_addr == 16'h5340) cfg_reg[1:0] <= i_wdata[1:0];
            if (i_addr == 16'h5344) cfg_reg[2] <= i_wdata[0];
            if (i_addr == 16'h5341) psc_reg <= i_wdata;
            if (i_addr == 16'h5342) carh_reg <= i_wdata[5:0];
            if (i_addr == 16'h5346) msk_reg <= i_wdata[2:0];
        end
    end

    sequence s_read(a);
        i_rd && i_addr == a;
    endsequence

    chk_psc_read: assert property (s_read(16'h5341) |=> o_rdata == psc_reg)
        else $error("tap select readback wrong");
    chk_carh_read: assert property (s_read(16'h5342) |=> o_rdata == {2'b00, carh_reg})
        else $error("high length readback wrong");
    chk_mask_read: assert property (s_read(16'h5346) |=> o_rdata == {5'h00, msk_reg})
        else $error("mask readback wrong");
    chk_unmapped_zero: assert property (i_rd && (i_addr < 16'h5340 || i_addr > 16'h5347) |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside its cycle");
    chk_tx_gated: assert property (o_ir_transmit_output |-> $past(cfg_reg == 3'b101))
        else $error("transmit pin high without tx level");
    chk_irq_masked: assert property (o_irq |-> msk_reg != 3'h0)
        else $error("interrupt with all sources masked");
    chk_irq_fall: assert property ($fell(o_irq) |-> $past(i_wr))
        else $error("interrupt dropped without a write");
endmodule // irt_core_assertions

bind irt_core irt_core_assertions u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_ir_transmit_output(o_ir_transmit_output), .o_irq(o_irq));
`default_nettype wire

// ### irt_ir_model.sv
`timescale 1ns/1ps
`default_nettype none
module irt_ir_model (
    input  wire logic i_clk,
    input  wire logic i_tx,
    output var logic  o_rx
);
    int   flash_count = 0;
    logic tx_reg      = 1'b0;

    initial o_rx = 1'b0;

    // The emitter flashes once per rising carrier edge; the bench counts them.
    always @(posedge i_clk)
    begin
        tx_reg <= i_tx;
        if (i_tx && !tx_reg) flash_count <= flash_count + 1;
    end

    // The receiver holds each level for whole clock cycles, as a real detector does.
    task automatic drive(input logic lv, input int n);
        begin
            @(posedge i_clk);
            o_rx <= lv;
            repeat (n) @(posedge i_clk);
        end
    endtask
endmodule // irt_ir_model
`default_nettype wire

// ### tb_infrared_remote_carrier_counter.sv
`timescale 1ns/1ps
`default_nettype none
module tb_infrared_remote_carrier_counter;
    logic        clk      = 1'b0;
    logic        nrst     = 1'b0;
    logic [15:0] addr     = 16'h0000;
    logic [7:0]  wdata    = 8'h00;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    logic [13:0] pcnt_reg = 14'h0000;
    logic [14:0] taps;
    logic [7:0]  rdata;
    logic        rx;
    logic        tx;
    logic        irq;
    int          err_total   = 0;
    int          check_count = 0;

    irt_core u_dut (.i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_psc_taps(taps), .i_ir_receive_input(rx), .o_ir_transmit_output(tx), .o_irq(irq));
    irt_ir_model u_ir (.i_clk(clk), .i_tx(tx), .o_rx(rx));

    initial forever #12.5 clk = ~clk;

    // Prescaler runs from time zero; tap n pulses once every 2^n cycles.
    always @(posedge clk) pcnt_reg <= pcnt_reg + 14'h0001;
    always_comb for (int n = 0; n < 15; n++) taps[n] = (pcnt_reg & ((14'h0001 << n) - 14'h0001)) == 14'h0000;

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        begin
            check_count++;
            if (g !== e)
            begin
                err_total++;
                $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic bus_rd(input logic [15:0] a, input logic [7:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk($sformatf("reg %h", a), e, rdata);
        end
    endtask

    // Counts one whole run of level lv on the pin, sampled mid-cycle.
    task automatic run_len(input logic lv, output int n);
        begin
            for (n = 0; tx !== lv && n < 300; n++) @(negedge clk);
            for (n = 0; tx === lv && n < 300; n++) @(negedge clk);
        end
    endtask

    task automatic t_regs;
        begin
            bus_rd(16'h5341, 8'h00);
            bus_rd(16'h5345, 8'h00);
            bus_rd(16'h5347, 8'h00);
            bus_rd(16'h5350, 8'h00);
            bus_wr(16'h5341, 8'hA5);
            bus_rd(16'h5341, 8'hA5);
            bus_wr(16'h5342, 8'hFF);
            bus_rd(16'h5342, 8'h3F);
            $display("test regs done");
        end
    endtask

    task automatic t_carrier;
        int hi;
        int lo;
        int f;
        begin
            bus_wr(16'h5342, 8'h02);
            bus_wr(16'h5343, 8'h01);
            bus_wr(16'h5344, 8'h01);
            for (int c = 0; c < 3; c++)
            begin
                bus_wr(16'h5341, {c[3:0], 4'hF});
                bus_wr(16'h5340, 8'h01);
                // The first high run can be cut short by the tap phase, so only later runs are timed.
                run_len(1'b1, hi);
                run_len(1'b0, lo);
                run_len(1'b1, hi);
                chk("high run", 8'(3 << c), 8'(hi));
                chk("low run", 8'(2 << c), 8'(lo));
                bus_wr(16'h5340, 8'h00);
            end
            bus_wr(16'h5341, 8'hFF);
            bus_wr(16'h5340, 8'h01);
            repeat (4) @(posedge clk);
            f = u_ir.flash_count;
            repeat (40) @(posedge clk);
            chk("reserved tap flashes", 8'h00, 8'(u_ir.flash_count - f));
            bus_wr(16'h5341, 8'h0F);
            bus_wr(16'h5344, 8'h00);
            // Let the registered pin and the model's edge counter settle before the baseline.
            repeat (2) @(posedge clk);
            f = u_ir.flash_count;
            repeat (30) @(posedge clk);
            chk("low level flashes", 8'h00, 8'(u_ir.flash_count - f));
            $display("test carrier done");
        end
    endtask

    task automatic t_length;
        int n;
        begin
            bus_wr(16'h5341, 8'hF1);
            bus_wr(16'h5346, 8'h01);
            bus_wr(16'h5345, 8'h04);
            for (n = 0; irq !== 1'b1 && n < 40; n++) @(negedge clk);
            chk("underflow window", 8'h01, 8'(n >= 6 && n <= 9));
            repeat (10) @(posedge clk);
            bus_rd(16'h5345, 8'h00);
            bus_rd(16'h5347, 8'h01);
            bus_wr(16'h5347, 8'h01);
            bus_rd(16'h5347, 8'h00);
            bus_wr(16'h5346, 8'h00);
            bus_wr(16'h5345, 8'h02);
            repeat (12) @(posedge clk);
            bus_rd(16'h5347, 8'h00);
            bus_wr(16'h5341, 8'hFF);
            bus_wr(16'h5345, 8'h03);
            repeat (20) @(posedge clk);
            bus_rd(16'h5345, 8'h03);
            $display("test length done");
        end
    endtask

    task automatic t_receive;
        begin
            bus_wr(16'h5341, 8'h0F);
            bus_wr(16'h5346, 8'h06);
            bus_wr(16'h5340, 8'h03);
            u_ir.drive(1'b1, 10);
            bus_rd(16'h5347, 8'h02);
            bus_wr(16'h5347, 8'h02);
            // A one-sample dip must be filtered; two samples would already count as a level.
            u_ir.drive(1'b0, 0);
            u_ir.drive(1'b1, 10);
            bus_rd(16'h5347, 8'h00);
            u_ir.drive(1'b0, 10);
            bus_rd(16'h5347, 8'h04);
            bus_wr(16'h5347, 8'h07);
            // Pulse timing: load 0xFF while the pin is low, read back after the rise; eight ticks elapse.
            bus_wr(16'h5341, 8'h00);
            bus_wr(16'h5345, 8'hFF);
            u_ir.drive(1'b1, 6);
            chk("rise irq", 8'h01, {7'h00, irq});
            bus_rd(16'h5345, 8'hF7);
            chk("tx pin in receive", 8'h00, {7'h00, tx});
            $display("test receive done");
        end
    endtask

    task automatic print_verdict;
        begin
            $display("comparisons %0d mismatches %0d", check_count, err_total);
            if (err_total == 0 && check_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    // The whole run needs under 400 cycles; stop a hang well past that.
    initial
    begin
        repeat (6000) @(posedge clk);
        err_total++;
        print_verdict();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_carrier();
        t_length();
        t_receive();
        print_verdict();
    end
endmodule // tb_infrared_remote_carrier_counter
`default_nettype wire
